/* common/event_buffer_pkg.sv */
// Shared constants and types for the event readout buffer
package event_buffer_pkg;

    localparam int          WORD_W            = 12;
    localparam int          STORE_ADDR_W      = 13;
    localparam int          PTR_W             = STORE_ADDR_W + 1;
    localparam int          SIZE_W            = 11;
    localparam int          COUNT_W           = 16;
    localparam int          OUT_FIFO_DEPTH    = 8;
    // Store word: sample word plus end-of-event flag
    localparam int          STORE_W           = WORD_W + 1;

    localparam logic [PTR_W-1:0]   STORE_WORDS       = 14'h2000;
    localparam logic [PTR_W-1:0]   PTR_ONE           = 14'h0001;
    localparam logic [PTR_W-1:0]   PTR_ZERO          = 14'h0000;

    localparam logic [SIZE_W-1:0]  HEADER_WORDS      = 11'h005;
    localparam logic [SIZE_W-1:0]  MEAS_WORDS        = 11'h00B;
    localparam logic [SIZE_W-1:0]  WAVE_WORDS        = 11'h400;
    localparam logic [SIZE_W-1:0]  FULL_EVENT_WORDS  = HEADER_WORDS + WAVE_WORDS + MEAS_WORDS;
    localparam logic [SIZE_W-1:0]  MIN_EVENT_WORDS   = HEADER_WORDS + MEAS_WORDS;
    localparam logic [SIZE_W-1:0]  SIZE_ONE          = 11'h001;
    localparam logic [SIZE_W-1:0]  SIZE_ZERO         = 11'h000;

    localparam logic [COUNT_W-1:0] COUNT_ZERO        = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE         = 16'h0001;

    localparam logic [7:0]         TRAILER_BYTE      = 8'h96;
    localparam int                 TRAILER_LSB       = 0;

    typedef enum logic {WR_IDLE, WR_EVENT} wr_state_t;

endpackage : event_buffer_pkg

/* test/event_readout_buffer_tb_top.sv */
// Self-checking bench for the event readout buffer
module event_readout_buffer_tb_top;
    import event_buffer_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i = 0, srst_i = 1, sw_reset_i = 0, clear_data_i = 0, clear_counters_i = 0;
    logic cfg_load_i = 0, acq_mode_i = 0, trigger_i = 0, evt_valid_i = 0, evt_last_i = 0, stall = 0;
    logic [SIZE_W-1:0]  cfg_words_i = 11'h010;
    logic [WORD_W-1:0]  evt_data_i = 12'h000;
    logic               trig_accept_o, trig_reject_o, run_suspended_o, evt_ready_o;
    logic               out_valid_o, out_last_o, out_ready_i, err_framing_o, err_oversize_o;
    logic [WORD_W-1:0]  out_data_o;
    logic [SIZE_W-1:0]  cfg_words_o;
    logic [COUNT_W-1:0] event_count_o;
    int failures = 0, cmp_count = 0, acc_n = 0, rej_n = 0;

    always #50 clk_i = ~clk_i;

    event_readout_buffer u_event_readout_buffer (.clk_i(clk_i), .srst_i(srst_i), .sw_reset_i(sw_reset_i),
        .clear_data_i(clear_data_i), .clear_counters_i(clear_counters_i), .cfg_load_i(cfg_load_i),
        .cfg_words_i(cfg_words_i), .acq_mode_i(acq_mode_i), .trigger_i(trigger_i),
        .trig_accept_o(trig_accept_o), .trig_reject_o(trig_reject_o), .run_suspended_o(run_suspended_o),
        .evt_valid_i(evt_valid_i), .evt_data_i(evt_data_i), .evt_last_i(evt_last_i),
        .evt_ready_o(evt_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
        .out_last_o(out_last_o), .out_ready_i(out_ready_i), .cfg_words_o(cfg_words_o),
        .event_count_o(event_count_o), .err_framing_o(err_framing_o), .err_oversize_o(err_oversize_o));

    readout_sink u_readout_sink (.clk_i(clk_i), .srst_i(srst_i), .stall_i(stall), .out_valid_i(out_valid_o),
        .out_data_i(out_data_o), .out_last_i(out_last_o), .out_ready_o(out_ready_i));

    always @(posedge clk_i)
    begin
        if (trig_accept_o === 1'b1)
            acc_n++;
        if (trig_reject_o === 1'b1)
            rej_n++;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic pulse(ref logic sig);
        @(negedge clk_i);
        sig = 1'b1;
        @(negedge clk_i);
        sig = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : pulse

    task automatic trig(input logic exp_acc);
        int a0, r0;
        a0 = acc_n;
        r0 = rej_n;
        pulse(trigger_i);
        check("trigger accepted", 16'(acc_n - a0), {15'h0000, exp_acc});
        check("trigger rejected", 16'(rej_n - r0), {15'h0000, ~exp_acc});
    endtask : trig

    // Trigger, then n words; the last carries the given trailer value
    task automatic send_event(input int n, input logic [11:0] tail);
        int k;
        trig(1'b1);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk_i);
            evt_valid_i = 1'b1;
            evt_data_i  = (i == n - 1) ? tail : 12'(i + 1);
            evt_last_i  = (i == n - 1);
            k = 0;
            do
            begin
                @(posedge clk_i);
                k++;
            end
            while (evt_ready_o !== 1'b1 && k < 50);
            if (k >= 50)
                check("word taken", 16'h0000, 16'h0001);
        end
        @(negedge clk_i);
        evt_valid_i = 1'b0;
        evt_last_i  = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask : send_event

    task automatic test_reset_values();
        check("cfg default", 16'(cfg_words_o), 16'h0410);
        check("event count", event_count_o, 16'h0000);
        check("suspended", 16'(run_suspended_o), 16'h0000);
        check("out valid", 16'(out_valid_o), 16'h0000);
    endtask : test_reset_values

    // Seven full events leave less than one event of room: store full
    task automatic test_full_events();
        for (int e = 0; e < 6; e++)
            send_event(1040, 12'h096);
        check("six events not full", 16'(run_suspended_o), 16'h0000);
        send_event(1040, 12'h096);
        check("seven events full", 16'(run_suspended_o), 16'h0001);
        trig(1'b0);
        check("out held back", 16'(out_valid_o), 16'h0000);
        pulse(sw_reset_i);
        check("count after sw reset", event_count_o, 16'h0000);
        check("suspended after sw reset", 16'(run_suspended_o), 16'h0000);
        check("cfg after sw reset", 16'(cfg_words_o), 16'h0410);
        check("out after sw reset", 16'(out_valid_o), 16'h0000);
    endtask : test_full_events

    task automatic test_readout_framing();
        int k;
        cfg_words_i = 11'h010;
        pulse(cfg_load_i);
        check("cfg loaded", 16'(cfg_words_o), 16'h0010);
        u_readout_sink.rx_q.delete();
        acq_mode_i = 1'b1;
        send_event(16, 12'h196);
        k = 0;
        while (u_readout_sink.rx_q.size() < 16 && k < 100)
        begin
            @(negedge clk_i);
            k++;
        end
        check("words pushed", 16'(u_readout_sink.rx_q.size()), 16'h0010);
        for (int i = 0; i < 16 && i < u_readout_sink.rx_q.size(); i++)
            check("pushed word", 16'(u_readout_sink.rx_q[i]),
                  (i == 15) ? 16'h1196 : 16'(i + 1));
        check("framing ok", 16'(err_framing_o), 16'h0000);
        check("count one", event_count_o, 16'h0001);
        send_event(17, 12'h095);
        check("framing error", 16'(err_framing_o), 16'h0001);
        check("oversize error", 16'(err_oversize_o), 16'h0001);
        pulse(clear_counters_i);
        check("count cleared", event_count_o, 16'h0000);
        check("errors cleared", {15'h0000, err_framing_o | err_oversize_o}, 16'h0000);
        acq_mode_i = 1'b0;
        pulse(clear_data_i);
    endtask : test_readout_framing

    // 512 minimum events exactly fill the store; one drained event resumes
    task automatic test_small_events();
        int k;
        for (int e = 0; e < 511; e++)
            send_event(16, 12'h096);
        check("511 events not full", 16'(run_suspended_o), 16'h0000);
        send_event(16, 12'h096);
        check("512 events full", 16'(run_suspended_o), 16'h0001);
        check("event count", event_count_o, 16'h0200);
        trig(1'b0);
        u_readout_sink.rx_q.delete();
        stall      = 1'b1;
        acq_mode_i = 1'b1;
        k = 0;
        while (run_suspended_o !== 1'b0 && k < 200)
        begin
            @(negedge clk_i);
            k++;
        end
        check("resumed after drain", 16'(run_suspended_o), 16'h0000);
        // Resume follows the store read; the stalled sink still holds part of the event
        k = 0;
        while (u_readout_sink.rx_q.size() < 16 && k < 100)
        begin
            @(negedge clk_i);
            k++;
        end
        check("last of first event", 16'(u_readout_sink.rx_q[15]), 16'h1096);
        send_event(16, 12'h096);
        acq_mode_i = 1'b0;
        pulse(clear_data_i);
        check("data cleared", 16'(out_valid_o), 16'h0000);
        check("count kept", event_count_o, 16'h0201);
        stall = 1'b0;
    endtask : test_small_events

    initial
    begin
        repeat (12) @(negedge clk_i);
        srst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        test_reset_values();
        test_full_events();
        test_readout_framing();
        test_small_events();
        final_report();
    end

    // Tests need about 20000 cycles; cut a hang well beyond that
    initial
    begin
        repeat (80000) @(posedge clk_i);
        failures++;
        final_report();
    end
endmodule : event_readout_buffer_tb_top

/* test/readout_sink.sv */
// Readout-side model: takes pushed event words, optionally stalling
module readout_sink
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        stall_i,
    input  wire logic        out_valid_i,
    input  wire logic [11:0] out_data_i,
    input  wire logic        out_last_i,
    output logic             out_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [12:0] rx_q[$];
    logic        phase;

    // Slow mode takes a word only every other cycle to back-pressure the store
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            phase       <= 1'b0;
            out_ready_o <= 1'b0;
        end
        else
        begin
            phase       <= ~phase;
            out_ready_o <= ~stall_i | phase;
            if (out_valid_i && out_ready_o)
                rx_q.push_back({out_last_i, out_data_i});
        end
    end
endmodule : readout_sink

/* verilog/event_readout_buffer.sv */
// Channel-pair event store with trigger gating, resets and event push readout
// Overview of operation
// - One 8k-word event store per channel pair, written by both channels.
// - A full event is 1040 twelve-bit words: header, samples, measurements.
// - Events held depends on configured size; up to 512 without samples.
// - While the store is full, triggers are rejected and the run is suspended.
// - Full ends and triggers resume once free space reaches one configured event size.
// - Samples leave raw; no correction is applied in the logic.
// - Global reset at power-up or by a software reset strobe.
// - Global reset discards buffered data and zeroes the event counter.
// - Global reset restores every configuration setting to its default.
// - Global reset zeroes all counters and clears latched errors.
// - Partial resets clear only the data path or only counters and latched errors.
// - In acquisition mode whole events are pushed out without polling.
// - Every event ends with a fixed trailer byte checked for framing.
module event_readout_buffer
    import event_buffer_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               srst_i,
    input  wire logic               sw_reset_i,
    input  wire logic               clear_data_i,
    input  wire logic               clear_counters_i,
    input  wire logic               cfg_load_i,
    input  wire logic [SIZE_W-1:0]  cfg_words_i,
    input  wire logic               acq_mode_i,
    input  wire logic               trigger_i,
    output logic                    trig_accept_o,
    output logic                    trig_reject_o,
    output logic                    run_suspended_o,
    input  wire logic               evt_valid_i,
    input  wire logic [WORD_W-1:0]  evt_data_i,
    input  wire logic               evt_last_i,
    output logic                    evt_ready_o,
    output logic                    out_valid_o,
    output logic [WORD_W-1:0]       out_data_o,
    output logic                    out_last_o,
    input  wire logic               out_ready_i,
    output logic [SIZE_W-1:0]       cfg_words_o,
    output logic [COUNT_W-1:0]      event_count_o,
    output logic                    err_framing_o,
    output logic                    err_oversize_o
);
    logic [STORE_W-1:0]      store [2**STORE_ADDR_W];
    wr_state_t               state;
    wr_state_t               next_state;
    logic [PTR_W-1:0]        wr_ptr;
    logic [PTR_W-1:0]        next_wr_ptr;
    logic [PTR_W-1:0]        commit_ptr;
    logic [PTR_W-1:0]        next_commit_ptr;
    logic [PTR_W-1:0]        rd_ptr;
    logic [PTR_W-1:0]        next_rd_ptr;
    logic [SIZE_W-1:0]       word_cnt;
    logic [SIZE_W-1:0]       next_word_cnt;
    logic [SIZE_W-1:0]       next_cfg_words;
    logic [COUNT_W-1:0]      next_event_count;
    logic                    next_accept;
    logic                    next_reject;
    logic                    next_full;
    logic                    next_evt_ready;
    logic                    next_err_framing;
    logic                    next_err_oversize;
    logic                    set_framing;
    logic                    set_oversize;
    logic                    pend;
    logic                    next_pend;
    logic [STORE_W-1:0]      rd_word;
    logic                    grst;
    logic                    clr_data;
    logic                    clr_cnt;
    logic                    wr_fire;
    logic                    rd_issue;
    logic                    avail;
    logic                    fifo_in_ready;
    logic [STORE_W-1:0]      fifo_out;
    logic [PTR_W-1:0]        next_used;

    // Space left once the given pointers are in effect
    function automatic logic [PTR_W-1:0] free_words(input logic [PTR_W-1:0] wp, input logic [PTR_W-1:0] rp);
        free_words = STORE_WORDS - (wp - rp);
    endfunction : free_words

    always_comb
    begin
        grst              = srst_i || sw_reset_i;
        clr_data          = grst || clear_data_i;
        clr_cnt           = grst || clear_counters_i;
        wr_fire           = evt_valid_i && evt_ready_o;
        avail             = commit_ptr != rd_ptr;
        rd_issue          = acq_mode_i && avail && (!pend || fifo_in_ready);
        next_state        = state;
        next_wr_ptr       = wr_ptr;
        next_commit_ptr   = commit_ptr;
        next_rd_ptr       = rd_ptr;
        next_word_cnt     = word_cnt;
        next_cfg_words    = cfg_words_o;
        next_event_count  = event_count_o;
        next_accept       = 1'b0;
        next_reject       = 1'b0;
        next_err_framing  = err_framing_o;
        next_err_oversize = err_oversize_o;
        next_pend         = pend;
        set_framing       = 1'b0;
        set_oversize      = 1'b0;

        // Sizes below header plus measurements are clamped so 512 events still fit
        if (cfg_load_i)
        begin
            next_cfg_words = (cfg_words_i < MIN_EVENT_WORDS) ? MIN_EVENT_WORDS : cfg_words_i;
        end

        unique case (state)
            WR_IDLE:
            begin
                if (trigger_i)
                begin
                    if (run_suspended_o)
                    begin
                        next_reject = 1'b1;
                    end
                    else
                    begin
                        next_accept   = 1'b1;
                        next_state    = WR_EVENT;
                        next_word_cnt = SIZE_ZERO;
                    end
                end
            end
            WR_EVENT:
            begin
                // A trigger during assembly is refused: the pair is busy
                next_reject = trigger_i;
                if (wr_fire)
                begin
                    next_wr_ptr   = wr_ptr + PTR_ONE;
                    next_word_cnt = word_cnt + SIZE_ONE;
                    if (word_cnt >= cfg_words_o)
                    begin
                        next_err_oversize = 1'b1;
                        set_oversize      = 1'b1;
                    end
                    if (evt_last_i)
                    begin
                        next_commit_ptr  = wr_ptr + PTR_ONE;
                        next_event_count = event_count_o + COUNT_ONE;
                        next_state       = WR_IDLE;
                        if (evt_data_i[TRAILER_LSB +: 8] != TRAILER_BYTE)
                        begin
                            next_err_framing = 1'b1;
                            set_framing      = 1'b1;
                        end
                    end
                end
            end
        endcase

        if (rd_issue)
        begin
            next_rd_ptr = rd_ptr + PTR_ONE;
            next_pend   = 1'b1;
        end
        else if (fifo_in_ready)
        begin
            next_pend = 1'b0;
        end

        if (clr_data)
        begin
            next_state      = WR_IDLE;
            next_wr_ptr     = PTR_ZERO;
            next_commit_ptr = PTR_ZERO;
            next_rd_ptr     = PTR_ZERO;
            next_pend       = 1'b0;
            next_accept     = 1'b0;
            next_reject     = 1'b0;
            next_event_count = event_count_o;
        end
        if (clr_cnt)
        begin
            next_event_count  = COUNT_ZERO;
            // An error caught in the clearing cycle survives a counter clear; a data clear drops the event too
            next_err_framing  = set_framing && !clr_data;
            next_err_oversize = set_oversize && !clr_data;
        end
        if (grst)
        begin
            next_cfg_words = FULL_EVENT_WORDS;
        end

        next_used      = next_wr_ptr - next_rd_ptr;
        next_full      = free_words(next_wr_ptr, next_rd_ptr) < {3'h0, next_cfg_words};
        next_evt_ready = (next_state == WR_EVENT) && (next_used != STORE_WORDS);
    end

    always_ff @(posedge clk_i)
    begin
        state           <= next_state;
        wr_ptr          <= next_wr_ptr;
        commit_ptr      <= next_commit_ptr;
        rd_ptr          <= next_rd_ptr;
        word_cnt        <= next_word_cnt;
        cfg_words_o     <= next_cfg_words;
        event_count_o   <= next_event_count;
        trig_accept_o   <= next_accept;
        trig_reject_o   <= next_reject;
        run_suspended_o <= next_full;
        evt_ready_o     <= next_evt_ready;
        err_framing_o   <= next_err_framing;
        err_oversize_o  <= next_err_oversize;
        pend            <= next_pend;
    end

    // Store array has no reset; pointers alone say what is valid
    always_ff @(posedge clk_i)
    begin
        if (wr_fire && !clr_data)
        begin
            store[wr_ptr[STORE_ADDR_W-1:0]] <= {evt_last_i, evt_data_i};
        end
        if (rd_issue)
        begin
            rd_word <= store[rd_ptr[STORE_ADDR_W-1:0]];
        end
    end

    // Small output queue decouples the store read from readout back-pressure
    shift_fifo #(
        .WIDTH (STORE_W),
        .DEPTH (OUT_FIFO_DEPTH)
    ) u_out_fifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .flush_i     (clr_data),
        .in_valid_i  (pend && !clr_data),
        .in_data_i   (rd_word),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (out_valid_o),
        .out_data_o  (fifo_out),
        .out_ready_i (out_ready_i)
    );

    assign out_data_o = fifo_out[WORD_W-1:0];
    assign out_last_o = fifo_out[WORD_W];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    logic [PTR_W-1:0] cur_free;
    assign cur_free = free_words(wr_ptr, rd_ptr);

    AST_FULL_REJECTS: assert property (trigger_i && run_suspended_o && !clear_data_i && !sw_reset_i
                                       |=> trig_reject_o && !trig_accept_o)
        else $error("trigger accepted while store full");
    AST_FULL_WHEN_SHORT: assert property (##1 (cur_free < {3'h0, cfg_words_o}) |-> run_suspended_o)
        else $error("full not raised with too little space");
    AST_RESUME_ON_DRAIN: assert property (##1 (cur_free >= {3'h0, cfg_words_o}) |-> !run_suspended_o)
        else $error("full held after space was drained");
    AST_GRST_CLEARS_DATA: assert property (sw_reset_i |=> event_count_o == COUNT_ZERO && !out_valid_o
                                           && commit_ptr == rd_ptr)
        else $error("global reset left data or count");
    AST_GRST_CFG: assert property (sw_reset_i |=> cfg_words_o == FULL_EVENT_WORDS)
        else $error("global reset did not restore configuration");
    AST_GRST_ERRS: assert property (sw_reset_i |=> !err_framing_o && !err_oversize_o)
        else $error("global reset left an error latched");
    AST_PARTIAL_KEEPS_COUNT: assert property (clear_data_i && !sw_reset_i && !clear_counters_i
                                              |=> event_count_o == $past(event_count_o))
        else $error("data clear changed the event counter");
    AST_COMMITTED_ONLY: assert property (rd_issue |-> commit_ptr != rd_ptr)
        else $error("read issued beyond committed data");
    AST_TRAILER_CHECK: assert property (wr_fire && evt_last_i && !clr_data
                                        && evt_data_i[TRAILER_LSB +: 8] != TRAILER_BYTE |=> err_framing_o)
        else $error("bad trailer not flagged");
    AST_PUSH_UNPOLLED: assert property (acq_mode_i && avail && !pend && fifo_in_ready && !clr_data
                                        |-> ##2 out_valid_o)
        else $error("committed event not pushed out");
    AST_WRITE_ADVANCES: assert property (wr_fire && !clr_data |=> wr_ptr == $past(wr_ptr) + PTR_ONE)
        else $error("store write did not advance");
    AST_MIN_SIZE: assert property (cfg_words_o >= MIN_EVENT_WORDS)
        else $error("configured size below minimum");

    COV_ACCEPT: cover property (trigger_i ##1 trig_accept_o);
    COV_REJECT_FULL: cover property (run_suspended_o && trigger_i ##1 trig_reject_o);
    COV_RESUME: cover property (run_suspended_o ##1 !run_suspended_o);
    COV_LAST_OUT: cover property (out_valid_o && out_ready_i && out_last_o);

endmodule : event_readout_buffer

/* verilog/shift_fifo.sv */
// Small shift-register FIFO with registered outputs and flags
module shift_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_DEPTH = CNT_W'(DEPTH);

    // Head always sits in slot 0 so the data output is a flip-flop
    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_in_ready;
    logic             next_out_valid;
    logic             push;
    logic             pop;
    logic [CNT_W-1:0] slot;

    always_comb
    begin
        push       = in_valid_i && in_ready_o;
        pop        = out_valid_o && out_ready_i;
        next_count = count;
        slot       = pop ? count - CNT_ONE : count;
        for (int i = 0; i < DEPTH; i++)
        begin
            next_mem[i] = (pop && i < DEPTH - 1) ? mem[i + 1] : mem[i];
            if (push && slot == CNT_W'(i))
            begin
                next_mem[i] = in_data_i;
            end
        end
        if (push && !pop)
        begin
            next_count = count + CNT_ONE;
        end
        else if (pop && !push)
        begin
            next_count = count - CNT_ONE;
        end
        if (flush_i)
        begin
            next_count = '0;
        end
        next_in_ready  = next_count != CNT_DEPTH;
        next_out_valid = next_count != '0;
    end

    always_ff @(posedge clk_i)
    begin
        mem <= next_mem;
        if (srst_i)
        begin
            count       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end
        else
        begin
            count       <= next_count;
            in_ready_o  <= next_in_ready;
            out_valid_o <= next_out_valid;
        end
    end

    assign out_data_o = mem[0];

endmodule : shift_fifo
